//--- rtl/twr_pkg.sv
// Shared constants for the three-wire register port.
package twr_pkg;
  localparam int NUM_REGS = 23;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int BIT_CNT_W = 3;
  localparam logic [BIT_CNT_W-1:0] LAST_BIT = 3'h7;
  localparam logic DIR_WRITE = 1'b0;
  localparam logic DIR_READ = 1'b1;
  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
  // Host serial clock half period: 600 ns, six system clocks at 10 MHz.
  // Read data needs five clocks to reach the host through both synchronisers,
  // so a shorter half period would make the host sample the previous bit.
  localparam int SYS_CLK_NS = 100;
  localparam int SCLK_HALF_NS = 600;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam int HALF_CNT_W = 4;
endpackage

//--- rtl/twr_link_if.sv
// Interface joining the host and device ends of the three-wire port.
`timescale 1ns/1ps
interface twr_link_if;
  logic sel;
  logic sclk;
  logic hostDataOut;
  logic hostDataOe;
  logic devDataOut;
  logic devDataOe;
  logic dataLine;

  // Wire resolution: undriven line is pulled high.
  assign dataLine = hostDataOe ? hostDataOut : (devDataOe ? devDataOut : 1'b1);

  modport host (output sel, output sclk, output hostDataOut, output hostDataOe, input dataLine);
  modport device (input sel, input sclk, output devDataOut, output devDataOe, input dataLine);
endinterface

//--- rtl/twr_sync.sv
// Two-flop synchroniser with edge detection for one pin.
`timescale 1ns/1ps
module twr_sync
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic pinIn,
  output logic level,
  output logic rise,
  output logic fall
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } twr_sync_type;

  twr_sync_type st_q;
  twr_sync_type st_d;

  always_comb
  begin
    st_d = st_q;
    st_d.s1 = pinIn;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign level = st_q.s2;
  assign rise = st_q.s2 & ~st_q.s3;
  assign fall = ~st_q.s2 & st_q.s3;
endmodule

//--- rtl/twr_device.sv
// Device end: serial port front end and the control register bank.
`timescale 1ns/1ps
module twr_device
  import twr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  twr_link_if.device link,
  output logic [NUM_REGS*DATA_W-1:0] regsActive,
  output logic loadStrobe
);
  typedef enum logic [1:0] {DV_IDLE, DV_ADDR, DV_WRITE, DV_READ} twr_dev_state_type;

  typedef struct packed {
    twr_dev_state_type state;
    logic [BIT_CNT_W-1:0] bitCnt;
    logic [DATA_W-1:0] shift;
    logic [ADDR_W-1:0] addr;
    logic dataOut;
    logic dataOe;
    logic load;
    logic [NUM_REGS*DATA_W-1:0] shadow;
    logic [NUM_REGS*DATA_W-1:0] active;
  } twr_dev_type;

  twr_dev_type st_q;
  twr_dev_type st_d;
  logic selLvl;
  logic selFall;
  logic sclkRise;
  logic sclkFall;
  logic dataLvl;

  twr_sync uSel (.clk(clk), .rst_b(rst_b), .pinIn(link.sel), .level(selLvl), .rise(), .fall(selFall));
  twr_sync uClk (.clk(clk), .rst_b(rst_b), .pinIn(link.sclk), .level(), .rise(sclkRise), .fall(sclkFall));
  twr_sync uDat (.clk(clk), .rst_b(rst_b), .pinIn(link.dataLine), .level(dataLvl), .rise(), .fall());

  always_comb
  begin
    logic [DATA_W-1:0] nextByte;
    nextByte = {st_q.shift[DATA_W-2:0], dataLvl};
    st_d = st_q;
    st_d.load = 1'b0;
    if (!selLvl)
    begin
      st_d.state = DV_IDLE;
      st_d.dataOe = 1'b0;
      st_d.bitCnt = '0;
    end
    else
    begin
      if (st_q.state == DV_IDLE)
        st_d.state = DV_ADDR;
      unique case (st_q.state)
        DV_IDLE, DV_ADDR, DV_WRITE:
        begin
          if (sclkFall)
          begin
            st_d.shift = nextByte;
            st_d.bitCnt = st_q.bitCnt + 3'h1;
            if (st_q.bitCnt == LAST_BIT)
            begin
              if (st_q.state == DV_WRITE)
              begin
                if (st_q.addr < ADDR_W'(NUM_REGS))
                  st_d.shadow[st_q.addr*DATA_W +: DATA_W] = nextByte;
                st_d.addr = st_q.addr + 7'h01;
              end
              else
              begin
                st_d.addr = nextByte[DATA_W-1:1];
                st_d.state = (nextByte[0] == DIR_READ) ? DV_READ : DV_WRITE;
              end
            end
          end
        end
        DV_READ:
        begin
          if (sclkRise)
          begin
            st_d.dataOe = 1'b1;
            st_d.bitCnt = st_q.bitCnt + 3'h1;
            if (st_q.bitCnt == '0)
            begin
              st_d.shift = (st_q.addr < ADDR_W'(NUM_REGS)) ? st_q.shadow[st_q.addr*DATA_W +: DATA_W] : REG_RESET;
              st_d.dataOut = st_d.shift[DATA_W-1];
              st_d.addr = st_q.addr + 7'h01;
            end
            else
            begin
              st_d.shift = {st_q.shift[DATA_W-2:0], 1'b0};
              st_d.dataOut = st_q.shift[DATA_W-2];
            end
          end
        end
      endcase
    end
    if (selFall)
    begin
      st_d.active = st_q.shadow;
      st_d.load = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_q <= '0;
      st_q.state <= DV_IDLE;
    end
    else
      st_q <= st_d;
  end

  // any start address, any length, any state.
  assign link.devDataOut = st_q.dataOut;
  assign link.devDataOe = st_q.dataOe;
  assign regsActive = st_q.active;
  assign loadStrobe = st_q.load;
endmodule

//--- rtl/twr_host.sv
// Host end: generates frame, serial clock and data for one transfer.
`timescale 1ns/1ps
module twr_host
  import twr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  twr_link_if.host link,
  input wire logic start,
  input wire logic isRead,
  input wire logic [ADDR_W-1:0] startAddr,
  input wire logic [4:0] octets,
  input wire logic [DATA_W-1:0] wrData,
  output logic wrTake,
  output logic [DATA_W-1:0] rdData,
  output logic rdValid,
  output logic busy
);
  typedef enum logic [1:0] {HS_IDLE, HS_LEAD, HS_SHIFT, HS_TAIL} twr_host_state_type;

  typedef struct packed {
    twr_host_state_type state;
    logic [HALF_CNT_W-1:0] half;
    logic sclk;
    logic sel;
    logic [DATA_W-1:0] shift;
    logic [BIT_CNT_W-1:0] bitCnt;
    logic [4:0] left;
    logic firstOctet;
    logic read;
    logic oe;
    logic dout;
    logic take;
    logic [DATA_W-1:0] rd;
    logic rdv;
  } twr_host_type;

  twr_host_type st_q;
  twr_host_type st_d;
  logic dataLvl;

  twr_sync uDat (.clk(clk), .rst_b(rst_b), .pinIn(link.dataLine), .level(dataLvl), .rise(), .fall());

  always_comb
  begin
    logic tick;
    tick = (st_q.half == HALF_CNT_W'(SCLK_HALF_CYC - 1));
    st_d = st_q;
    st_d.take = 1'b0;
    st_d.rdv = 1'b0;
    if (st_q.state != HS_IDLE)
      st_d.half = tick ? '0 : st_q.half + 4'h1;
    unique case (st_q.state)
      HS_IDLE:
        // caller holds start low until power-on reset is over.
        if (start)
        begin
          st_d.sel = 1'b1;
          st_d.oe = 1'b1;
          st_d.read = isRead;
          st_d.shift = {startAddr, isRead ? DIR_READ : DIR_WRITE};
          st_d.left = octets;
          st_d.firstOctet = 1'b1;
          st_d.bitCnt = '0;
          st_d.half = '0;
          st_d.state = HS_LEAD;
        end
      HS_LEAD:
        if (tick)
        begin
          st_d.dout = st_q.shift[DATA_W-1];
          st_d.state = HS_SHIFT;
        end
      HS_SHIFT:
        if (tick)
        begin
          st_d.sclk = ~st_q.sclk;
          if (st_q.sclk)
          begin
            st_d.bitCnt = st_q.bitCnt + 3'h1;
            if (st_q.read && !st_q.firstOctet)
              st_d.shift = {st_q.shift[DATA_W-2:0], dataLvl};
            else
              st_d.shift = {st_q.shift[DATA_W-2:0], 1'b0};
            if (st_q.bitCnt == LAST_BIT)
            begin
              st_d.firstOctet = 1'b0;
              if (!st_q.firstOctet)
                st_d.left = st_q.left - 5'h01;
              if (st_q.read && !st_q.firstOctet)
              begin
                st_d.rd = {st_q.shift[DATA_W-2:0], dataLvl};
                st_d.rdv = 1'b1;
              end
              // release line after address in read
              if (st_q.read)
                st_d.oe = 1'b0;
              if (!st_q.read)
              begin
                st_d.shift = wrData;
                st_d.take = (st_q.left != '0);
              end
              if ((st_q.firstOctet ? st_q.left : st_q.left - 5'h01) == '0)
                st_d.state = HS_TAIL;
            end
          end
          else if (!st_q.read || st_q.firstOctet)
            // host changes data on rising edge
            st_d.dout = st_q.shift[DATA_W-1];
        end
      HS_TAIL:
        if (tick && st_q.sel)
          st_d.sel = 1'b0;
        // drive line again later
        // The device lets go of the line three clocks after select falls, so the host
        // waits one more half period to avoid both ends driving at once.
        else if (tick)
        begin
          st_d.oe = 1'b1;
          st_d.state = HS_IDLE;
        end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_q <= '0;
      st_q.state <= HS_IDLE;
      st_q.oe <= 1'b1;
    end
    else
      st_q <= st_d;
  end

  // full write is address 0 with 23 octets via octets input.
  assign link.sel = st_q.sel;
  assign link.sclk = st_q.sclk;
  assign link.hostDataOut = st_q.dout;
  assign link.hostDataOe = st_q.oe;
  assign wrTake = st_q.take;
  assign rdData = st_q.rd;
  assign rdValid = st_q.rdv;
  assign busy = (st_q.state != HS_IDLE);
endmodule

//--- testbench/twr_link_monitor.sv
// Protocol checker on the three-wire link.
`timescale 1ns/1ps
module twr_link_monitor
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic sel,
  input wire logic sclk,
  input wire logic hostDataOut,
  input wire logic hostDataOe,
  input wire logic devDataOut,
  input wire logic devDataOe,
  input wire logic dataLine
);
  // ---
  // Assertions
  // ---
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  dev_quiet_a: assert property (!sel [*4] |-> !devDataOe)
    else $error("device drives outside frame");
  one_driver_a: assert property (!(hostDataOe && devDataOe))
    else $error("both ends drive the data line");
  clk_still_a: assert property (!sel |-> !sclk)
    else $error("serial clock runs outside frame");
  clk_half_a: assert property ($rose(sclk) |=> sclk [*3])
    else $error("serial clock high phase too short");
  host_low_a: assert property (sel && hostDataOe && $changed(hostDataOut) |-> !$past(sclk))
    else $error("host data changed while clock high");
  dev_rise_a: assert property (devDataOe && $past(devDataOe) && $changed(devDataOut) |-> sclk)
    else $error("device data changed while clock low");
  dev_take_a: assert property ($rose(devDataOe) |-> sclk && sel && !hostDataOe)
    else $error("device took line off a rising edge");
  host_free_a: assert property ($fell(hostDataOe) |-> sel && !sclk)
    else $error("host released line at wrong moment");
  cover property ($rose(devDataOe));
  cover property ($fell(sel));
  cover property (sel && hostDataOe && sclk);
  cover property (sel && !hostDataOe && !devDataOe && dataLine);
endmodule

//--- testbench/three_wire_register_port_tb.sv
// Bench joining host and device ends and checking the link.
`timescale 1ns/1ps
module three_wire_register_port_tb;
  import twr_pkg::*;
  logic clk, rst_b, start, isRead, wrTake, rdValid, busy, loadStrobe;
  logic [ADDR_W-1:0] startAddr;
  logic [4:0] octets;
  logic [DATA_W-1:0] wrData, rdData, sh, ao, d0;
  logic [NUM_REGS*DATA_W-1:0] regsActive;
  logic [DATA_W-1:0] m [NUM_REGS];
  int num_errors, n_compared, nf, cyc;
  twr_link_if u_twr_link_if();
  twr_host u_twr_host(.clk(clk), .rst_b(rst_b), .link(u_twr_link_if.host), .start(start), .isRead(isRead),
    .startAddr(startAddr), .octets(octets), .wrData(wrData), .wrTake(wrTake), .rdData(rdData),
    .rdValid(rdValid), .busy(busy));
  twr_device u_twr_device(.clk(clk), .rst_b(rst_b), .link(u_twr_link_if.device), .regsActive(regsActive),
    .loadStrobe(loadStrobe));
  twr_link_monitor u_twr_link_monitor(.clk(clk), .rst_b(rst_b), .sel(u_twr_link_if.sel),
    .sclk(u_twr_link_if.sclk), .hostDataOut(u_twr_link_if.hostDataOut), .hostDataOe(u_twr_link_if.hostDataOe),
    .devDataOut(u_twr_link_if.devDataOut), .devDataOe(u_twr_link_if.devDataOe),
    .dataLine(u_twr_link_if.dataLine));
  // ---
  // Clock, wire capture and timeout
  // ---
  initial
  begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  // The bench samples the wire itself so a shared slip in both ends still shows.
  always @(negedge u_twr_link_if.sclk)
  begin
    if (u_twr_link_if.sel === 1'b1)
    begin
      sh = {sh[6:0], u_twr_link_if.dataLine};
      nf++;
      if (nf == 8) ao = sh;
      if (nf == 16) d0 = sh;
    end
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      num_errors++;
      $display("BAD timeout exp idle got hung");
      close_out;
    end
  end
  // ---
  // Tasks
  // ---
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic chk_regs;
    for (int i = 0; i < NUM_REGS; i++) chk("reg", m[i], regsActive[i*8+:8]);
  endtask
  task automatic xfer(input logic rd, input logic [6:0] a, input logic [4:0] n, input logic [7:0] b);
    int k;
    int t;
    bit ld;
    k = 0;
    ld = 1'b0;
    if (!rd) for (int j = 0; j < n; j++) m[a+j] = b + 8'(j) * 8'h1D;
    @(posedge clk);
    #1;
    isRead = rd;
    startAddr = a;
    octets = n;
    wrData = b;
    nf = 0;
    start = 1;
    @(posedge clk);
    #1;
    start = 0;
    for (t = 0; t < 3000 && busy === 1'b1; t++)
    begin
      if (wrTake === 1'b1)
      begin
        k++;
        wrData = b + 8'(k) * 8'h1D;
      end
      if (rdValid === 1'b1)
      begin
        chk("read data", m[a+k], rdData);
        k++;
      end
      if (loadStrobe === 1'b1) ld = 1'b1;
      @(posedge clk);
      #1;
    end
    chk("falls", 8'(8 * (n + 1)), 8'(nf));
    chk("addr octet", {a, rd}, ao);
    chk("wire octet", m[a], d0);
    chk("host oe", 8'h01, 8'(u_twr_link_if.hostDataOe));
    if (rd) chk("read count", 8'(n), 8'(k));
    chk("busy", 8'h00, 8'(busy));
    for (t = 0; t < 20 && !ld; t++)
    begin
      @(posedge clk);
      #1;
      if (loadStrobe === 1'b1) ld = 1'b1;
    end
    chk("load", 8'h01, 8'(ld));
    chk_regs;
    $display("test %s at %0d done", rd ? "read" : "write", a);
  endtask
  task automatic close_out;
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ---
  // Main sequence
  // ---
  initial
  begin
    rst_b = 0;
    start = 0;
    isRead = 0;
    startAddr = 7'h00;
    octets = 5'h01;
    wrData = 8'h00;
    foreach (m[i]) m[i] = REG_RESET;
    repeat (16) @(posedge clk);
    #1;
    rst_b = 1;
    chk_regs;
    xfer(1'b0, 7'h14, 5'h03, 8'h5A);
    xfer(1'b0, 7'h00, 5'h16, 8'hC3);
    xfer(1'b1, 7'h03, 5'h05, 8'h00);
    xfer(1'b1, 7'h00, 5'h17, 8'h00);
    close_out;
  end
endmodule
